// >>> sram_tap_instruction_scan.sv
// Purpose: boundary-scan test port of an x18 late-write SRAM
// Assumes: TCK is its own domain; pads arrive asynchronously
// Notes:   observe-only port; RAM logic lives elsewhere
//
// How it works
// - Unconnected pad cells always capture and shift a logic 1.
// - True and complementary RAM clocks have separate scan cells.
// - Capture-IR loads 01 into the two lowest instruction bits.
// - Shift-IR moves instruction register between TDI and TDO.
// - New instruction takes effect only at update-IR.
// - Bypass puts the one-bit bypass register in the shift path.
// - Sample copies all input and I/O pad values at capture-DR.
// - Sample puts boundary register between TDI and TDO in shift-DR.
// - Update-DR under sample changes nothing, like pause-DR.
// - All-zeros acts as sample but holds RAM outputs high impedance.
// - Identification captures ID ROM and shifts the ID register.
// - Identification is selected at power-up and in test-logic-reset.
// - Port only observes pads; never drives RAM or preloads outputs.
// - Boundary register is 51 cells; cell 1 is nearest TDO.
// - Instruction register is three bits wide.
// - Codes: 001 ident, 100 sample, 111 bypass, 010 sample-Z, 000 zeros.
// - Registers take TDI on rising TCK, drive TDO on falling TCK.
`timescale 1ns/1ps
module sram_tap_instruction_scan
	import sram_tap_pkg::*;
#(
	parameter logic [10:0] ID_MAKER    = 11'h2A5, // Arbitrary value
	parameter logic [5:0]  ID_RESERVED = 6'h00,   // Arbitrary value
	parameter logic [3:0]  ID_REVISION = 4'h0     // Arbitrary value
) (
	input  wire logic       CLK_SYS_IN, // System clock, 50 MHz
	input  wire logic       RST_B_IN,   // Synchronous reset, active low
	input  wire logic       TCK_IN,     // Test clock
	input  wire logic       TMS_IN,     // Test mode select
	input  wire logic       TDI_IN,     // Test data in
	input  ram_pads_s       PADS_IN,    // RAM pad buffer levels
	output logic            TDO_OUT,    // Test data out
	output logic            TDO_OE_OUT, // TDO driven while shifting
	output logic            RAM_HIZ_OUT,// RAM outputs forced off
	output instr_t          INSTR_OUT   // Active instruction, sys side
);
	localparam logic [`ID_LEN-1:0] ID_ROM = {
		ID_REVISION,
		`ID_DEPTH_X18,
		`ID_WIDTH_X18,
		ID_RESERVED,
		ID_MAKER,
		`ID_PRESENCE
	};

	// Pads in scan order; index 0 is cell 1, next to TDO
	function automatic logic [`BSR_LEN-1:0] boundary_image(
		input ram_pads_s p
	);
		boundary_image = {
			p.mode_pin_one,              // 51
			p.address_pins[17:14],       // 50..47
			p.data_lane_high[8:4],       // 46..42
			p.global_write_enable,       // 41
			`BSR_PLACEHOLDER,            // 40
			`BSR_PLACEHOLDER,            // 39
			p.chip_select_pin,           // 38
			`BSR_PLACEHOLDER,            // 37
			p.byte_write_high,           // 36
			p.data_lane_high[3:0],       // 35..32
			p.address_pins[13:10],       // 31..28
			`BSR_PLACEHOLDER,            // 27
			p.address_pins[9:8],         // 26..25
			`BSR_PLACEHOLDER,            // 24
			p.address_pins[7:4],         // 23..20
			p.data_lane_low[8:4],        // 19..15
			p.output_enable_pin,         // 14
			p.ram_clock_true,            // 13
			p.ram_clock_comp,            // 12
			p.byte_write_low,            // 11
			p.data_lane_low[3:0],        // 10..7
			p.sleep_pin,                 // 6
			p.address_pins[3:0],         // 5..2
			p.mode_pin_two               // 1
		};
	endfunction

	// Which data register an instruction selects
	function automatic dr_sel_e decode_dr(input instr_t code);
		case (code)
			`INSTR_IDCODE:  decode_dr = DR_IDENT;
			`INSTR_SAMPLE:  decode_dr = DR_BOUNDARY;
			`INSTR_EXTEST:  decode_dr = DR_BOUNDARY;
			`INSTR_SAMPLEZ: decode_dr = DR_BOUNDARY;
			`INSTR_BYPASS:  decode_dr = DR_BYPASS;
			default:        decode_dr = DR_BYPASS;
		endcase
	endfunction

	// Codes that keep the RAM outputs off
	function automatic logic outputs_off(input instr_t code);
		outputs_off = (code == `INSTR_EXTEST) ||
			(code == `INSTR_SAMPLEZ);
	endfunction

	// ---------------- TCK domain ----------------

	logic                    tck_rst_b;
	logic [`PAD_BITS-1:0]    pads_flat;
	ram_pads_s               pads_tck;
	tap_state_e              tap_state;
	instr_t                  ir_shift;
	instr_t                  ir_active;
	instr_t                  next_active;
	logic                    send_word;
	dr_sel_e                 dr_sel;
	logic                    bypass_bit;
	logic [`BSR_LEN-1:0]     bsr;
	logic [`ID_LEN-1:0]      id_reg;
	logic                    next_tdo;
	logic                    shifting;
	logic                    hiz_tck;
	instr_t                  instr_hold;
	logic                    req_tgl;
	logic                    ack_tck;

	// Power-on reset brought into the test clock domain
	scan_sync #(
		.W(1)
	) u_rst_sync (
		.clk_in(TCK_IN),
		.d_in  (RST_B_IN),
		.q_out (tck_rst_b)
	);

	// Pads change with the RAM clock, not with TCK
	scan_sync #(
		.W(`PAD_BITS)
	) u_pad_sync (
		.clk_in(TCK_IN),
		.d_in  (PADS_IN),
		.q_out (pads_flat)
	);

	assign pads_tck = ram_pads_s'(pads_flat);

	tap_ctrl u_ctrl (
		.clk_in   (TCK_IN),
		.rst_b_in (tck_rst_b),
		.tms_in   (TMS_IN),
		.state_out(tap_state)
	);

	assign dr_sel = decode_dr(ir_active);

	// Code in force after this edge; TCK may stop right after update-IR
	always_comb begin
		next_active = ir_active;
		if (tap_state == ST_RESET) begin
			next_active = `INSTR_IDCODE;
		end else if (tap_state == ST_UPDATE_IR) begin
			next_active = ir_shift;
		end
	end

	// Instruction shift stage
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			ir_shift <= `INSTR_IDCODE;
		end else if (tap_state == ST_CAPTURE_IR) begin
			ir_shift <= `IR_CAPTURE;
		end else if (tap_state == ST_SHIFT_IR) begin
			ir_shift <= {TDI_IN, ir_shift[`IR_WIDTH-1:1]};
		end
	end

	// Active instruction
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			ir_active <= `INSTR_IDCODE;
		end else if (tap_state == ST_RESET) begin
			ir_active <= `INSTR_IDCODE;
		end else if (tap_state == ST_UPDATE_IR) begin
			ir_active <= ir_shift;
		end
	end

	// Bypass cell
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			bypass_bit <= `BYPASS_CAPTURE;
		end else if (dr_sel == DR_BYPASS) begin
			if (tap_state == ST_CAPTURE_DR) begin
				bypass_bit <= `BYPASS_CAPTURE;
			end else if (tap_state == ST_SHIFT_DR) begin
				bypass_bit <= TDI_IN;
			end
		end
	end

	// Boundary register; update-DR leaves it and the pads alone
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			bsr <= '0;
		end else if (dr_sel == DR_BOUNDARY) begin
			if (tap_state == ST_CAPTURE_DR) begin
				bsr <= boundary_image(pads_tck);
			end else if (tap_state == ST_SHIFT_DR) begin
				bsr <= {TDI_IN, bsr[`BSR_LEN-1:1]};
			end
		end
	end

	// Identification register
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			id_reg <= ID_ROM;
		end else if (dr_sel == DR_IDENT) begin
			if (tap_state == ST_CAPTURE_DR) begin
				id_reg <= ID_ROM;
			end else if (tap_state == ST_SHIFT_DR) begin
				id_reg <= {TDI_IN, id_reg[`ID_LEN-1:1]};
			end
		end
	end

	// Serial output source
	always_comb begin
		next_tdo = TDO_OUT;
		shifting = 1'b0;
		case (tap_state)
			ST_SHIFT_IR: begin
				next_tdo = ir_shift[0];
				shifting = 1'b1;
			end
			ST_SHIFT_DR: begin
				shifting = 1'b1;
				case (dr_sel)
					DR_BOUNDARY: next_tdo = bsr[0];
					DR_IDENT:    next_tdo = id_reg[0];
					default:     next_tdo = bypass_bit;
				endcase
			end
			default: begin
				next_tdo = TDO_OUT;
				shifting = 1'b0;
			end
		endcase
	end

	// Output changes on the falling edge only
	always_ff @(negedge TCK_IN) begin
		if (!tck_rst_b) begin
			TDO_OUT <= 1'b0;
		end else begin
			TDO_OUT <= next_tdo;
		end
	end

	// Driver enable follows the shift states on the same edge
	always_ff @(negedge TCK_IN) begin
		if (!tck_rst_b) begin
			TDO_OE_OUT <= 1'b0;
		end else begin
			TDO_OE_OUT <= shifting;
		end
	end

	// Outputs off for as long as either off-code is loaded
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			hiz_tck <= 1'b0;
		end else begin
			hiz_tck <= outputs_off(next_active);
		end
	end

	// New word leaves on the edge that loads it, once the last one is taken
	assign send_word = (req_tgl == ack_tck) && (instr_hold != next_active);

	// Word offered to the system side, stable while a request is open
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			instr_hold <= `INSTR_IDCODE;
		end else if (send_word) begin
			instr_hold <= next_active;
		end
	end

	// Request toggle
	always_ff @(posedge TCK_IN) begin
		if (!tck_rst_b) begin
			req_tgl <= 1'b0;
		end else if (send_word) begin
			req_tgl <= ~req_tgl;
		end
	end

	// ---------------- System domain ----------------

	logic hiz_sys;
	logic req_sys;
	logic req_seen;

	scan_sync #(
		.W(1)
	) u_hiz_sync (
		.clk_in(CLK_SYS_IN),
		.d_in  (hiz_tck),
		.q_out (hiz_sys)
	);

	scan_sync #(
		.W(1)
	) u_req_sync (
		.clk_in(CLK_SYS_IN),
		.d_in  (req_tgl),
		.q_out (req_sys)
	);

	scan_sync #(
		.W(1)
	) u_ack_sync (
		.clk_in(TCK_IN),
		.d_in  (req_seen),
		.q_out (ack_tck)
	);

	// Only a level to the RAM output gating; never data or control
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			RAM_HIZ_OUT <= 1'b0;
		end else begin
			RAM_HIZ_OUT <= hiz_sys;
		end
	end

	// Held word is stable while the request is pending
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			INSTR_OUT <= `INSTR_IDCODE;
		end else if (req_sys != req_seen) begin
			INSTR_OUT <= instr_hold;
		end
	end

	// Acknowledge returns the request level to the test clock side
	always_ff @(posedge CLK_SYS_IN) begin
		if (!RST_B_IN) begin
			req_seen <= 1'b0;
		end else begin
			req_seen <= req_sys;
		end
	end
endmodule

// >>> sram_tap_cfg.svh
// Purpose: constants of the SRAM boundary-scan test port
// Assumes: x18 organisation, three-bit instruction register
// Notes:   included by the package only; the modules use its macros
`ifndef SRAM_TAP_CFG_SVH
`define SRAM_TAP_CFG_SVH

// Register lengths
`define IR_WIDTH        3
`define BSR_LEN         51
`define ID_LEN          32
`define PAD_BITS        46

// Instruction codes, MSB on the left
`define INSTR_EXTEST    3'h0
`define INSTR_IDCODE    3'h1
`define INSTR_SAMPLEZ   3'h2
`define INSTR_SAMPLE    3'h4
`define INSTR_BYPASS    3'h7

// Pattern loaded in capture-IR
`define IR_CAPTURE      3'h1

// Scan cell values
`define BSR_PLACEHOLDER 1'h1
`define BYPASS_CAPTURE  1'h0

// Identification word fields
`define ID_PRESENCE     1'h1
`define ID_WIDTH_X18    5'h03
`define ID_DEPTH_X18    5'h06

`endif

// >>> sram_tap_pkg.sv
// Purpose: types shared by the SRAM test port modules
// Assumes: constants come from the cfg header
// Notes:   pad struct is grouped by function, not by scan order
package sram_tap_pkg;
	`include "sram_tap_cfg.svh"

	typedef logic [`IR_WIDTH-1:0] instr_t;

	typedef enum logic [3:0] {
		ST_RESET,
		ST_IDLE,
		ST_SELECT_DR,
		ST_CAPTURE_DR,
		ST_SHIFT_DR,
		ST_EXIT1_DR,
		ST_PAUSE_DR,
		ST_EXIT2_DR,
		ST_UPDATE_DR,
		ST_SELECT_IR,
		ST_CAPTURE_IR,
		ST_SHIFT_IR,
		ST_EXIT1_IR,
		ST_PAUSE_IR,
		ST_EXIT2_IR,
		ST_UPDATE_IR
	} tap_state_e;

	typedef enum logic [1:0] {
		DR_BYPASS,
		DR_BOUNDARY,
		DR_IDENT
	} dr_sel_e;

	typedef struct packed {
		logic        mode_pin_two;
		logic        mode_pin_one;
		logic [17:0] address_pins;
		logic        sleep_pin;
		logic [8:0]  data_lane_low;
		logic [8:0]  data_lane_high;
		logic        byte_write_low;
		logic        byte_write_high;
		logic        ram_clock_true;
		logic        ram_clock_comp;
		logic        output_enable_pin;
		logic        chip_select_pin;
		logic        global_write_enable;
	} ram_pads_s;
endpackage

// >>> scan_sync.sv
// Purpose: two-flop synchroniser for levels
// Assumes: input is stable long enough to be seen
// Notes:   no reset, so it can also carry a reset level
`timescale 1ns/1ps
module scan_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in, // Destination clock
	input  wire logic [W-1:0] d_in,   // Level from another domain
	output logic      [W-1:0] q_out   // Synchronised level
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_in) begin
		meta  <= d_in;
		q_out <= meta;
	end
endmodule

// >>> tap_ctrl.sv
// Purpose: sixteen-state test port controller
// Assumes: runs on TCK, synchronous active-low reset
// Notes:   five TMS highs reach the reset state from anywhere
`timescale 1ns/1ps
module tap_ctrl
	import sram_tap_pkg::*;
(
	input  wire logic clk_in,    // TCK
	input  wire logic rst_b_in,  // Power-on reset, TCK domain
	input  wire logic tms_in,    // Mode select
	output tap_state_e state_out // Controller state
);
	tap_state_e next_state;

	always_comb begin
		next_state = state_out;
		case (state_out)
			ST_RESET:      next_state = tms_in ? ST_RESET : ST_IDLE;
			ST_IDLE:       next_state = tms_in ? ST_SELECT_DR : ST_IDLE;
			ST_SELECT_DR:  next_state = tms_in ? ST_SELECT_IR : ST_CAPTURE_DR;
			ST_CAPTURE_DR: next_state = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR:   next_state = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR:   next_state = tms_in ? ST_UPDATE_DR : ST_PAUSE_DR;
			ST_PAUSE_DR:   next_state = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR:   next_state = tms_in ? ST_UPDATE_DR : ST_SHIFT_DR;
			ST_UPDATE_DR:  next_state = tms_in ? ST_SELECT_DR : ST_IDLE;
			ST_SELECT_IR:  next_state = tms_in ? ST_RESET : ST_CAPTURE_IR;
			ST_CAPTURE_IR: next_state = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR:   next_state = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR:   next_state = tms_in ? ST_UPDATE_IR : ST_PAUSE_IR;
			ST_PAUSE_IR:   next_state = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR:   next_state = tms_in ? ST_UPDATE_IR : ST_SHIFT_IR;
			ST_UPDATE_IR:  next_state = tms_in ? ST_SELECT_DR : ST_IDLE;
			default:       next_state = ST_RESET;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_out <= ST_RESET;
		end else begin
			state_out <= next_state;
		end
	end
endmodule

// >>> sram_tap_instruction_scan_asserts.sv
// Purpose: pin-level checks of the SRAM test port
// Assumes: TCK checks key off TMS runs from reset
// Notes:   bound to the top module
`timescale 1ns/1ps
module sram_tap_instruction_scan_asserts
	import sram_tap_pkg::*;
(
	input wire logic   CLK_SYS_IN,  // System clock
	input wire logic   RST_B_IN,    // Reset, active low
	input wire logic   TCK_IN,      // Test clock
	input wire logic   TMS_IN,      // Mode select
	input wire logic   TDO_OUT,     // Test data out
	input wire logic   TDO_OE_OUT,  // TDO enable
	input wire logic   RAM_HIZ_OUT, // RAM outputs off
	input wire instr_t INSTR_OUT    // Active instruction
);
	sequence to_reset;
		TMS_IN [*5];
	endsequence
	sequence ir_entry;
		to_reset ##1 !TMS_IN ##1 TMS_IN [*2] ##1 !TMS_IN [*2];
	endsequence
	sequence dr_entry;
		to_reset ##1 !TMS_IN ##1 TMS_IN ##1 !TMS_IN [*2];
	endsequence

	a_reset_ident: assert property (@(posedge CLK_SYS_IN)
		!RST_B_IN |=> INSTR_OUT == 3'h1 && !RAM_HIZ_OUT)
		else $error("reset left wrong code");
	a_hiz_follow: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		$changed(INSTR_OUT) |-> ##6 RAM_HIZ_OUT == (INSTR_OUT inside {3'h0, 3'h2}))
		else $error("disable does not match code");
	a_hiz_rise: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		$rose(RAM_HIZ_OUT) |-> ##[0:6] INSTR_OUT inside {3'h0, 3'h2})
		else $error("disable without zeros code");
	a_hiz_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_B_IN)
		$fell(RAM_HIZ_OUT) |-> ##[0:6] !(INSTR_OUT inside {3'h0, 3'h2}))
		else $error("disable dropped under zeros code");
	a_oe_reset: assert property (@(posedge TCK_IN) disable iff (!RST_B_IN)
		to_reset |=> !TDO_OE_OUT)
		else $error("TDO driven in reset state");
	a_ir_capture: assert property (@(posedge TCK_IN) disable iff (!RST_B_IN)
		ir_entry |=> TDO_OUT && TDO_OE_OUT)
		else $error("first IR bit not 1");
	a_ir_bit1: assert property (@(posedge TCK_IN) disable iff (!RST_B_IN)
		ir_entry ##1 !TMS_IN |=> !TDO_OUT && TDO_OE_OUT)
		else $error("second IR bit not 0");
	a_id_first: assert property (@(posedge TCK_IN) disable iff (!RST_B_IN)
		dr_entry |=> TDO_OUT && TDO_OE_OUT)
		else $error("ID bit 0 not 1");
	a_tdo_hold: assert property (@(posedge TCK_IN) disable iff (!RST_B_IN)
		!TDO_OE_OUT && !$past(TDO_OE_OUT) |-> $stable(TDO_OUT))
		else $error("TDO moved while idle");
endmodule

bind sram_tap_instruction_scan sram_tap_instruction_scan_asserts u_chk (
	.CLK_SYS_IN, .RST_B_IN, .TCK_IN, .TMS_IN,
	.TDO_OUT, .TDO_OE_OUT, .RAM_HIZ_OUT, .INSTR_OUT
);

// >>> scan_host.sv
// Purpose: board scan controller model
// Assumes: TCK runs only while a sequence is sent
// Notes:   TDO sampled at each rising TCK
`timescale 1ns/1ps
module scan_host (
	output logic      tck_out, // Test clock
	output logic      tms_out, // Mode select
	output logic      tdi_out, // Test data
	input  wire logic tdo_in   // Test data back
);
	logic [63:0] cap;

	initial begin
		tck_out = 1'h0;
		tms_out = 1'h1;
		tdi_out = 1'h0;
	end

	// One 15 ns period, link held across the rising edge
	task automatic pulse(input logic m, input logic d);
		tms_out = m;
		tdi_out = d;
		#7.5 tck_out = 1'h1;
		cap = {tdo_in, cap[63:1]};
		#7.5 tck_out = 1'h0;
	endtask

	task automatic walk(input logic [7:0] m, input int n);
		for (int i = 0; i < n; i++)
			pulse(m[i], 1'h0);
	endtask

	// From idle: shift n bits through IR or DR, back to idle
	task automatic scan(input logic ir, input logic [63:0] d, input int n,
		output logic [63:0] q);
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
			pulse(i == n - 1, d[i]);
		q = cap >> (64 - n);
		walk(8'h01, 2);
	endtask
endmodule

// >>> tb_sram_tap_instruction_scan.sv
// Purpose: self-checking bench of the SRAM test port
// Assumes: link clock made by the scan host model
// Notes:   pads change only while the link is idle
`timescale 1ns/1ps
module tb_sram_tap_instruction_scan
	import sram_tap_pkg::*;
();
	typedef struct {
		instr_t      code;
		int          n;
		logic [45:0] pads;
		logic [63:0] exp;
		logic        hiz;
	} row_s;

	logic        clk_sys;
	logic        rst_b;
	ram_pads_s   pads;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe;
	logic        hiz;
	instr_t      instr;
	logic [63:0] q;
	int          error_cnt;
	int          samples_checked;
	int          cycles;
	wire         tdo_w = tdo_oe ? tdo : 1'hZ;
	row_s        rows [9] = '{
		'{3'h1, 32, 46'h0, 64'h030C054B, 1'h0},
		'{3'h7, 8, 46'h0, 64'h4A, 1'h0},
		'{3'h4, 51, 46'h1234_5678_9ABC, 64'h0, 1'h0},
		'{3'h0, 51, 46'h0, 64'h0, 1'h1},
		'{3'h2, 51, 46'h3FFF_FFFF_FFFF, 64'h0, 1'h1},
		'{3'h4, 51, 46'h2DCB_A987_6543, 64'h0, 1'h0},
		'{3'h6, 8, 46'h0, 64'h4A, 1'h0},
		'{3'h3, 8, 46'h0, 64'h4A, 1'h0},
		'{3'h5, 8, 46'h0, 64'h4A, 1'h0}
	};

	sram_tap_instruction_scan u_sram_tap_instruction_scan (
		.CLK_SYS_IN  (clk_sys),
		.RST_B_IN    (rst_b),
		.TCK_IN      (tck),
		.TMS_IN      (tms),
		.TDI_IN      (tdi),
		.PADS_IN     (pads),
		.TDO_OUT     (tdo),
		.TDO_OE_OUT  (tdo_oe),
		.RAM_HIZ_OUT (hiz),
		.INSTR_OUT   (instr)
	);
	scan_host u_scan_host (
		.tck_out (tck),
		.tms_out (tms),
		.tdi_out (tdi),
		.tdo_in  (tdo_w)
	);

	function automatic logic [63:0] bsr(input ram_pads_s p);
		return {13'h0, p.mode_pin_one, p.address_pins[17:14], p.data_lane_high[8:4],
			p.global_write_enable, 2'h3, p.chip_select_pin, 1'h1, p.byte_write_high,
			p.data_lane_high[3:0], p.address_pins[13:10], 1'h1, p.address_pins[9:8],
			1'h1, p.address_pins[7:4], p.data_lane_low[8:4], p.output_enable_pin,
			p.ram_clock_true, p.ram_clock_comp, p.byte_write_low,
			p.data_lane_low[3:0], p.sleep_pin, p.address_pins[3:0], p.mode_pin_two};
	endfunction

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end

	initial begin
		rst_b = 1'h0;
		pads = '0;
		error_cnt = 0;
		samples_checked = 0;
		cycles = 0;
		fork
			repeat (5) @(posedge clk_sys);
			u_scan_host.walk(8'hFF, 6);
		join
		#1 rst_b = 1'h1;
		u_scan_host.walk(8'h1F, 6);
		chk("mode", {hiz, instr}, 4'h1);
		foreach (rows[i]) begin
			@(posedge clk_sys);
			#1 pads = rows[i].pads;
			u_scan_host.scan(1'h1, 64'(rows[i].code), 3, q);
			chk("ir", q, 64'h1);
			repeat (8) @(posedge clk_sys);
			chk("mode", {hiz, instr}, {rows[i].hiz, rows[i].code});
			u_scan_host.scan(1'h0, 64'hA5, rows[i].n, q);
			chk("dr", q, rows[i].n == 51 ? bsr(pads) : rows[i].exp);
			repeat (6) @(posedge clk_sys);
			chk("after", {hiz, instr}, {rows[i].hiz, rows[i].code});
		end
		// Park a zeros code in pause-IR: old code stays in force
		u_scan_host.walk(8'h43, 8);
		repeat (10) @(posedge clk_sys);
		chk("held", {hiz, instr}, 4'h5);
		u_scan_host.walk(8'h03, 3);
		repeat (8) @(posedge clk_sys);
		chk("zeros", {hiz, instr}, 4'h8);
		u_scan_host.walk(8'h1F, 6);
		repeat (8) @(posedge clk_sys);
		chk("reset", {hiz, instr}, 4'h1);
		u_scan_host.scan(1'h0, 64'h0, 32, q);
		chk("id", q, 64'h030C054B);
		print_verdict();
	end
endmodule
